// file: hdl/rtcpi_trim_irq.sv
// How it works
// - seven-bit offset code trims timekeeping in 3.05 ppm steps, up to 189.1 ppm
// - trim touches only the time counters; reference output stays untrimmed
// - correction applied once per twenty seconds, at seconds 00, 20 and 40
// - codes 02h..3Fh slow by code minus one steps; 00h, 01h do nothing
// - codes 7Fh..42h speed up by 128 minus code steps; 41h, 40h do nothing
// - power-on flag loads defaults: offset and first control register zero
// - periodic interrupt at 2 Hz, 1 Hz, minute, hour or monthly
// - pulse waveform at 2 Hz or 1 Hz, level waveform for second..month
// - periodic state mirrored in a readable flag for polling
// - pulse mode: seconds increment lags the pin falling edge by two oscillator ticks (46 us rounded up, about 61 us)
// - pulse mode: writing seconds drives the pin low and realigns the train
// - level mode: seconds increment coincides with pin falling edge
// - correction stretches or shrinks the interrupt period once per 20 s
// - 1 Hz pulse: correction changes only the high phase, up to 3.784 ms
// - 2 Hz pulse: correction changes only a low phase, up to 3.784 ms
// - level mode: one-second period changes by at most 3.784 ms
// - read-only status bits read zero and ignore writes
`timescale 1ns/1ps

`include "rtcpi_params.svh"

module rtcpi_trim_irq
   import rtcpi_pkg::*;
#(
   parameter int unsigned TICKS_PER_STEP = `RTCPI_TICKS_PER_STEP
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // apb slave
   input wire rtcpi_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // oscillator and supply monitor pins
   input wire logic osc_32k,
   input wire logic power_on_detect,
   // calendar event
   input wire logic month_first_day,
   // pins and status
   output logic ref_freq_out_pin,
   output logic irq_out,
   output logic irq_oe,
   output logic trim_test_mode
);

   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   localparam logic [14:0] LAG_TICKS = 15'(`RTCPI_LAG_TICKS);

   if (TICKS_PER_STEP < 1 || TICKS_PER_STEP * 63 > 255) begin : g_step_check
      $error("TICKS_PER_STEP out of range");
   end

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] osc_sync_r;
   logic [2:0] pon_sync_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync_r <= 3'h0;
         pon_sync_r <= 3'h0;
      end else begin
         osc_sync_r <= {osc_sync_r[1:0], osc_32k};
         pon_sync_r <= {pon_sync_r[1:0], power_on_detect};
      end
   end

   wire tick = osc_sync_r[1] & ~osc_sync_r[2];
   wire pon_rise = pon_sync_r[1] & ~pon_sync_r[2];

   // untrimmed oscillator copy
   assign ref_freq_out_pin = osc_sync_r[2];

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   wire setup = apb_req.psel & ~apb_req.penable;
   wire access = apb_req.psel & apb_req.penable;
   wire [3:0] idx = apb_req.paddr[5:2];
   wire aligned = (apb_req.paddr[1:0] == 2'h0);
   wire hit_sec = aligned & (idx == `RTCPI_IDX_SECONDS);
   wire hit_min = aligned & (idx == `RTCPI_IDX_MINUTES);
   wire hit_hour = aligned & (idx == `RTCPI_IDX_HOURS);
   wire hit_trim = aligned & (idx == `RTCPI_IDX_RATE_TRIM);
   wire hit_c1 = aligned & (idx == `RTCPI_IDX_CTRL_FIRST);
   wire hit_c2 = aligned & (idx == `RTCPI_IDX_CTRL_SECOND);
   wire mapped = hit_sec | hit_min | hit_hour | hit_trim | hit_c1 | hit_c2;
   wire wr_en = access & apb_req.pwrite & mapped;
   wire wr_sec = wr_en & hit_sec;
   wire wr_trim = wr_en & hit_trim;
   wire wr_c1 = wr_en & hit_c1;
   wire wr_c2 = wr_en & hit_c2;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [7:0] trim_r;
   logic [7:0] ctrl1_r;
   logic pon_r;
   logic pflag_r;
   logic [5:0] sec_r;
   logic [5:0] min_r;
   logic [4:0] hour_r;
   logic [14:0] ph_r;
   logic [7:0] adj_left_r;
   logic adj_fast_r;
   logic irq_oe_r;
   logic [31:0] prdata_r;

   wire rtcpi_mode_e mode = rtcpi_mode_e'(ctrl1_r[2:0]);
   wire pulse_mode = (mode == PM_PULSE_2HZ) | (mode == PM_PULSE_1HZ);
   wire level_mode = (mode == PM_LEVEL_SEC) | (mode == PM_LEVEL_MIN) |
                     (mode == PM_LEVEL_HOUR) | (mode == PM_LEVEL_MONTH);

   assign trim_test_mode = trim_r[`RTCPI_TRIM_TEST_BIT];

   // ----------------------------------------------------------------------
   // time base with rate trim
   // ----------------------------------------------------------------------
   wire rtcpi_trim_s trim_dec = rtcpi_trim_decode(trim_r[6:0]);
   wire [7:0] trim_ticks = 8'(trim_dec.steps * TICKS_PER_STEP);

   // correction sits in the second half of seconds 00, 20 and 40: high phase at 1 Hz, low phase at 2 Hz
   wire adj_zone = (ph_r >= `RTCPI_HALF_PHASE) & (adj_left_r != 8'h00);
   wire [14:0] ph_hold = ph_r;
   wire [14:0] ph_skip = ph_r + 15'h0002;
   wire [14:0] ph_step = ph_r + 15'h0001;
   wire [14:0] ph_nxt = !tick ? ph_r :
                        (adj_zone & ~adj_fast_r) ? ph_hold :
                        (adj_zone & adj_fast_r) ? ph_skip : ph_step;
   wire [14:0] sec_phase = pulse_mode ? LAG_TICKS : 15'h0000;
   wire sec_edge = tick & (ph_nxt != ph_r) & (ph_nxt == sec_phase) & ~wr_sec;
   wire [5:0] sec_nxt = (sec_r == 6'd59) ? 6'h00 : sec_r + 6'h01;
   wire min_edge = sec_edge & (sec_r == 6'd59);
   wire hour_edge = min_edge & (min_r == 6'd59);
   wire trim_slot = (sec_nxt == 6'd0) | (sec_nxt == 6'(`RTCPI_TRIM_PERIOD_S)) |
                    (sec_nxt == 6'(2 * `RTCPI_TRIM_PERIOD_S));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= 15'h0000;
      end else if (wr_sec) begin
         ph_r <= LAG_TICKS;
      end else begin
         ph_r <= ph_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         adj_left_r <= 8'h00;
         adj_fast_r <= 1'b0;
      end else if (sec_edge & trim_slot) begin
         adj_left_r <= trim_ticks;
         adj_fast_r <= trim_dec.fast;
      end else if (tick & adj_zone & ~wr_sec) begin
         adj_left_r <= adj_left_r - 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sec_r <= 6'h00;
      end else if (wr_sec) begin
         sec_r <= (apb_req.pwdata[5:0] > 6'd59) ? 6'h00 : apb_req.pwdata[5:0];
      end else if (sec_edge) begin
         sec_r <= sec_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         min_r <= 6'h00;
         hour_r <= 5'h00;
      end else if (min_edge) begin
         min_r <= (min_r == 6'd59) ? 6'h00 : min_r + 6'h01;
         if (hour_edge) begin
            hour_r <= (hour_r == 5'd23) ? 5'h00 : hour_r + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------------
   // periodic interrupt
   // ----------------------------------------------------------------------
   wire pulse_low = ((mode == PM_PULSE_1HZ) & ~ph_r[14]) |
                    ((mode == PM_PULSE_2HZ) & ~ph_r[13]);
   wire level_event = ((mode == PM_LEVEL_SEC) & sec_edge) |
                      ((mode == PM_LEVEL_MIN) & min_edge) |
                      ((mode == PM_LEVEL_HOUR) & hour_edge) |
                      ((mode == PM_LEVEL_MONTH) & month_first_day);
   wire pflag_clr = wr_c2 & ~apb_req.pwdata[`RTCPI_C2_PFLAG_BIT];
   wire pon_clr = wr_c2 & ~apb_req.pwdata[`RTCPI_C2_PON_BIT];
   wire irq_drive = pulse_low | (level_mode & pflag_r);
   wire flag_view = pulse_mode ? pulse_low : pflag_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pflag_r <= 1'b0;
         irq_oe_r <= 1'b0;
      end else begin
         pflag_r <= level_event | (pflag_r & ~pflag_clr & ~pon_rise);
         irq_oe_r <= irq_drive;
      end
   end

   assign irq_out = 1'b0;
   assign irq_oe = irq_oe_r;

   // ----------------------------------------------------------------------
   // control registers and power-on defaults
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trim_r <= `RTCPI_RST_RATE_TRIM;
         ctrl1_r <= `RTCPI_RST_CTRL_FIRST;
         pon_r <= 1'b1;
      end else if (pon_rise) begin
         trim_r <= `RTCPI_RST_RATE_TRIM;
         ctrl1_r <= `RTCPI_RST_CTRL_FIRST;
         pon_r <= 1'b1;
      end else begin
         if (wr_trim) begin
            trim_r <= apb_req.pwdata[7:0];
         end
         if (wr_c1) begin
            ctrl1_r <= apb_req.pwdata[7:0];
         end
         if (pon_clr) begin
            pon_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read data, latched in the setup phase
   // ----------------------------------------------------------------------
   wire [7:0] c2_view = {3'b000, pon_r, 1'b0, flag_view, 2'b00};
   wire [7:0] rd_byte = hit_sec ? {2'b00, sec_r} :
                        hit_min ? {2'b00, min_r} :
                        hit_hour ? {3'b000, hour_r} :
                        hit_trim ? trim_r :
                        hit_c1 ? ctrl1_r :
                        hit_c2 ? c2_view : 8'h00;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup) begin
         prdata_r <= {24'h000000, rd_byte};
      end
   end

   assign prdata = prdata_r;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_ref_freq_copy: assert property (tick |=> ref_freq_out_pin)
      else $error("reference output not following oscillator");
   a_trim_slow_hold: assert property (tick && adj_zone && !adj_fast_r && !wr_sec |=> ph_r == $past(ph_r))
      else $error("slow trim did not hold the time base");
   a_trim_fast_skip: assert property (tick && adj_zone && adj_fast_r && !wr_sec |=> ph_r == $past(ph_r) + 15'h0002)
      else $error("fast trim did not skip a tick");
   a_trim_load_slot: assert property (adj_left_r > $past(adj_left_r) |-> $past(sec_edge) && $past(trim_slot))
      else $error("correction loaded outside a twenty second slot");
   a_trim_amount: assert property (sec_edge && sec_nxt == 6'd0 && !pon_rise |=> adj_left_r == $past(trim_ticks))
      else $error("correction amount mismatch");
   a_trim_bounded: assert property (adj_left_r <= 8'(63 * TICKS_PER_STEP))
      else $error("correction exceeds maximum");
   a_pon_defaults: assert property (pon_rise && !level_event |=> trim_r == 8'h00 && ctrl1_r == 8'h00 && pon_r && !pflag_r)
      else $error("power-on defaults not loaded");
   a_sec_write_low: assert property (wr_sec && pulse_mode && !wr_c1 && !pon_rise |-> ##2 irq_oe)
      else $error("seconds write did not pull the pin low");
   a_pulse_lag: assert property (sec_edge && pulse_mode |=> pulse_low ##1 irq_oe)
      else $error("seconds advanced outside the low phase");
   a_level_edge: assert property (sec_edge && mode == PM_LEVEL_SEC |=> pflag_r ##1 irq_oe)
      else $error("level interrupt not raised at seconds increment");
   a_level_hold: assert property (level_mode && pflag_r && !pflag_clr && !pon_rise |=> pflag_r)
      else $error("level flag dropped without host clear");
   a_mode_off: assert property (mode == PM_OFF |=> !irq_oe)
      else $error("pin driven while periodic interrupt is off");
   a_ro_zero: assert property (access && !apb_req.pwrite && hit_c2 |-> prdata[7:5] == 3'b000)
      else $error("read-only bits not zero");
   a_flag_mirror: assert property (pulse_mode && irq_oe |-> $past(flag_view))
      else $error("flag does not mirror pin");

   // ----------------------------------------------------------------------
   // register checks
   // ----------------------------------------------------------------------

   a_rd_latch: assert property (setup |=> prdata == {24'h000000, $past(rd_byte)})
      else $error("read data not latched in setup");

   a_c2_spare_zero: assert property (setup && hit_c2 |=> prdata[3] == 1'b0 && prdata[1:0] == 2'b00)
      else $error("spare status bits not zero");

   a_ro_time_kept: assert property (wr_en && (hit_min || hit_hour) && !min_edge |=> min_r == $past(min_r) && hour_r == $past(hour_r))
      else $error("read-only time register written");

   a_test_bit_out: assert property (wr_trim && !pon_rise |=> trim_test_mode == $past(apb_req.pwdata[7]))
      else $error("test bit not stored");

   a_ctrl1_write: assert property (wr_c1 && !pon_rise |=> ctrl1_r == $past(apb_req.pwdata[7:0]))
      else $error("first control write lost");

   a_pon_clear: assert property (pon_clr && !pon_rise |=> !pon_r)
      else $error("power-on flag not cleared");

   // ----------------------------------------------------------------------
   // time base checks
   // ----------------------------------------------------------------------

   a_plain_step: assert property (tick && !adj_zone && !wr_sec |=> ph_r == $past(ph_r) + 15'h0001)
      else $error("untrimmed tick did not step");

   a_trim_idle: assert property (!tick && !wr_sec |=> ph_r == $past(ph_r))
      else $error("time base moved without a tick");

   a_trim_spend: assert property (tick && adj_zone && !wr_sec && !(sec_edge && trim_slot) |=> adj_left_r == $past(adj_left_r) - 8'h01)
      else $error("correction not spent one per tick");

   a_trim_window: assert property (!$past(sec_edge) && adj_left_r < $past(adj_left_r) |-> $past(ph_r) >= `RTCPI_HALF_PHASE)
      else $error("correction spent in first half");

   a_slot_only: assert property (sec_edge && !trim_slot |=> adj_left_r <= $past(adj_left_r))
      else $error("correction loaded off slot");

   a_sec_set: assert property (wr_sec |=> ph_r == LAG_TICKS)
      else $error("seconds write did not realign");

   a_sec_wrap: assert property (sec_edge && sec_r == 6'd59 |=> sec_r == 6'h00)
      else $error("seconds did not wrap");

   // ----------------------------------------------------------------------
   // interrupt checks
   // ----------------------------------------------------------------------

   a_flag_set: assert property (level_event |=> pflag_r)
      else $error("level event did not set flag");

   a_flag_quiet: assert property (!level_mode && !pflag_r |=> !pflag_r)
      else $error("flag set outside level mode");

   a_pulse_pin: assert property (pulse_mode |=> irq_oe == $past(pulse_low))
      else $error("pulse pin does not follow phase");

   a_level_release: assert property (level_mode && pflag_clr && !level_event |-> ##2 !irq_oe)
      else $error("pin not released after flag clear");

   // ----------------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------------

   c_slow_load: cover property (sec_edge && trim_slot && trim_ticks != 8'h00 && !trim_dec.fast);
   c_fast_load: cover property (sec_edge && trim_slot && trim_ticks != 8'h00 && trim_dec.fast);
   c_level_clear: cover property (pflag_r && pflag_clr);
   c_sec_write_pulse: cover property (wr_sec && pulse_mode);
   c_pulse_wrap: cover property (sec_edge && pulse_mode && trim_slot);

endmodule : rtcpi_trim_irq

// file: hdl/rtcpi_params.svh
`ifndef RTCPI_PARAMS_SVH
`define RTCPI_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RTCPI_IDX_SECONDS 4'h0
`define RTCPI_IDX_MINUTES 4'h1
`define RTCPI_IDX_HOURS 4'h2
`define RTCPI_IDX_RATE_TRIM 4'h7
`define RTCPI_IDX_CTRL_FIRST 4'hE
`define RTCPI_IDX_CTRL_SECOND 4'hF

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define RTCPI_RST_RATE_TRIM 8'h00
`define RTCPI_RST_CTRL_FIRST 8'h00
`define RTCPI_TRIM_TEST_BIT 7
`define RTCPI_C2_PON_BIT 4
`define RTCPI_C2_PFLAG_BIT 2
`define RTCPI_TRIM_SLOW_MIN 7'h02
`define RTCPI_TRIM_FAST_MIN 7'h42
`define RTCPI_TRIM_FAST_BASE 8'h80

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RTCPI_OSC_HZ 32768
`define RTCPI_TICKS_PER_STEP 2
`define RTCPI_TRIM_PERIOD_S 20
`define RTCPI_LAG_US 46
`define RTCPI_LAG_TICKS ((`RTCPI_LAG_US * `RTCPI_OSC_HZ + 999999) / 1000000)
`define RTCPI_HALF_PHASE 15'h4000

`endif

// file: hdl/rtcpi_pkg.sv
`include "rtcpi_params.svh"

package rtcpi_pkg;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      PM_OFF         = 3'b000,
      PM_PULSE_2HZ   = 3'b001,
      PM_PULSE_1HZ   = 3'b010,
      PM_LEVEL_SEC   = 3'b011,
      PM_LEVEL_MIN   = 3'b100,
      PM_LEVEL_HOUR  = 3'b101,
      PM_LEVEL_MONTH = 3'b110,
      PM_OFF_ALT     = 3'b111
   } rtcpi_mode_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [5:0] paddr;
      logic [31:0] pwdata;
   } rtcpi_apb_req_s;

   typedef struct packed {
      logic fast;
      logic [5:0] steps;
   } rtcpi_trim_s;

   // ----------------------------------------------------------------------
   // offset code decode
   // ----------------------------------------------------------------------
   function automatic rtcpi_trim_s rtcpi_trim_decode(input logic [6:0] code);
      rtcpi_trim_s t;
      t = '0;
      t.fast = code[6];
      if (!code[6]) begin
         t.steps = (code < `RTCPI_TRIM_SLOW_MIN) ? 6'h00 : 6'(code - 7'h01);
      end else begin
         t.steps = (code < `RTCPI_TRIM_FAST_MIN) ? 6'h00 : 6'(`RTCPI_TRIM_FAST_BASE - {1'b0, code});
      end
      return t;
   endfunction : rtcpi_trim_decode

endpackage : rtcpi_pkg

// file: tb/rtcpi_host_model.sv
`timescale 1ns/1ps

module rtcpi_host_model
   import rtcpi_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // apb master side
   output rtcpi_apb_req_s apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // open-drain interrupt pin
   input wire logic irq_out,
   input wire logic irq_oe,
   output logic irq_pin
);
   // ----------------------------------------------------------------------
   // pin resolution
   // ----------------------------------------------------------------------
   // pull-up holds the pin high whenever the device lets go of it
   assign irq_pin = irq_oe ? irq_out : 1'b1;

   initial begin
      apb_req = '0;
   end

   // ----------------------------------------------------------------------
   // one apb transfer, bounded wait on pready
   // ----------------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                       output logic err, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      rd = '0;
      err = 1'b0;
      @(posedge mclk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr;
      apb_req.paddr <= {idx, 2'b00};
      apb_req.pwdata <= {24'h000000, wd};
      @(posedge mclk);
      apb_req.penable <= 1'b1;
      while (!ok && n < 16) begin
         @(posedge mclk);
         n++;
         if (pready === 1'b1) begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      apb_req <= '0;
   endtask : xfer
endmodule : rtcpi_host_model

// file: tb/rtcpi_trim_irq_tb.sv
`timescale 1ns/1ps

`include "rtcpi_params.svh"

module rtcpi_trim_irq_tb
   import rtcpi_pkg::*;
;
   logic mclk, rst_n, osc_32k, power_on_detect, month_first_day;
   rtcpi_apb_req_s apb_req;
   logic [31:0] prdata;
   logic pready, pslverr, ref_freq_out_pin, irq_out, irq_oe, trim_test_mode, irq_pin, ref_q;
   int failures = 0;
   int n_checks = 0;
   int ref_rises = 0;

   rtcpi_trim_irq rtcpi_trim_irq_i (.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k), .power_on_detect(power_on_detect),
      .month_first_day(month_first_day), .ref_freq_out_pin(ref_freq_out_pin), .irq_out(irq_out),
      .irq_oe(irq_oe), .trim_test_mode(trim_test_mode));

   rtcpi_host_model rtcpi_host_model_i (.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_out(irq_out), .irq_oe(irq_oe), .irq_pin(irq_pin));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      ref_q <= ref_freq_out_pin;
      if (ref_freq_out_pin === 1'b1 && ref_q === 1'b0) ref_rises++;
   end

   // ----------------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      logic ok;
      rtcpi_host_model_i.xfer(wr, idx, wd, rd, err, ok);
      if (ok !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
      logic [31:0] rd;
      logic err;
      bus(1'b1, idx, wd, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] mask, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      logic err;
      bus(1'b0, idx, 8'h00, rd, err);
      check(rd & mask, exp, what);
   endtask : rd_chk

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   // oscillator ticks; the line rests low between bursts
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         osc_32k <= 1'b1;
         @(posedge mclk);
         osc_32k <= 1'b0;
      end
   endtask : pulses

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset;
      rd_chk(`RTCPI_IDX_RATE_TRIM, 32'hFFFFFFFF, 32'h00000000, "trim reset");
      rd_chk(`RTCPI_IDX_CTRL_FIRST, 32'hFFFFFFFF, 32'h00000000, "ctrl1 reset");
      rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'hFFFFFFFF, 32'h00000010, "ctrl2 reset");
      check(irq_pin, 1'b1, "pin idle");
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      logic [31:0] rd, m0;
      logic err;
      wr(`RTCPI_IDX_RATE_TRIM, 8'h7D);
      rd_chk(`RTCPI_IDX_RATE_TRIM, 32'hFFFFFFFF, 32'h0000007D, "trim rw");
      check(trim_test_mode, 1'b0, "test off");
      wr(`RTCPI_IDX_RATE_TRIM, 8'h80);
      idle(2);
      check(trim_test_mode, 1'b1, "test on");
      wr(`RTCPI_IDX_RATE_TRIM, 8'h00);
      idle(2);
      check(trim_test_mode, 1'b0, "test cleared");
      wr(`RTCPI_IDX_CTRL_SECOND, 8'hFF);
      rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'hFFFFFFFF, 32'h00000010, "ctrl2 ones");
      wr(`RTCPI_IDX_CTRL_SECOND, 8'h00);
      rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'hFFFFFFFF, 32'h00000000, "pon cleared");
      bus(1'b0, `RTCPI_IDX_MINUTES, 8'h00, m0, err);
      wr(`RTCPI_IDX_MINUTES, 8'h33);
      rd_chk(`RTCPI_IDX_MINUTES, 32'hFFFFFFFF, m0, "minutes ro");
      bus(1'b1, 4'h4, 8'h5A, rd, err);
      check(err, 1'b1, "unmapped write err");
      bus(1'b0, 4'h4, 8'h00, rd, err);
      check({rd[30:0], err}, 32'h00000001, "unmapped read");
      $display("test regs done");
   endtask : t_regs

   task automatic t_ref;
      int snap;
      wr(`RTCPI_IDX_RATE_TRIM, 8'h42);
      snap = ref_rises;
      pulses(100);
      idle(6);
      check(ref_rises - snap, 100, "ref edges untrimmed");
      wr(`RTCPI_IDX_RATE_TRIM, 8'h00);
      $display("test ref done");
   endtask : t_ref

   task automatic t_pulse;
      rtcpi_mode_e modes[2] = '{PM_PULSE_2HZ, PM_PULSE_1HZ};
      int low_ticks[2] = '{8190, 16382};
      logic [7:0] sec0[2] = '{8'h05, 8'h3B};
      for (int i = 0; i < 2; i++) begin
         wr(`RTCPI_IDX_CTRL_FIRST, {5'h00, modes[i]});
         wr(`RTCPI_IDX_SECONDS, sec0[i]);
         idle(4);
         check(irq_pin, 1'b0, "low after seconds write");
         pulses(low_ticks[i] - 1);
         idle(6);
         check(irq_pin, 1'b0, "low phase end");
         pulses(1);
         idle(6);
         check(irq_pin, 1'b1, "high phase start");
         if (i == 1) begin
            pulses(16382);
            idle(6);
            check(irq_pin, 1'b1, "high phase end");
            pulses(2);
            idle(6);
            check(irq_pin, 1'b0, "pin fell at wrap");
            rd_chk(`RTCPI_IDX_SECONDS, 32'hFFFFFFFF, 32'h0000003B, "seconds lag fall");
            pulses(2);
            idle(6);
            rd_chk(`RTCPI_IDX_SECONDS, 32'hFFFFFFFF, 32'h00000000, "seconds after lag");
         end
         wr(`RTCPI_IDX_SECONDS, 8'h05);
         idle(4);
         check(irq_pin, 1'b0, "realigned low");
         rd_chk(`RTCPI_IDX_SECONDS, 32'hFFFFFFFF, 32'h00000005, "seconds kept");
      end
      $display("test pulse done");
   endtask : t_pulse

   task automatic t_level;
      rtcpi_mode_e modes[3] = '{PM_OFF, PM_OFF_ALT, PM_LEVEL_MONTH};
      for (int i = 0; i < 3; i++) begin
         wr(`RTCPI_IDX_CTRL_FIRST, {5'h00, modes[i]});
         @(posedge mclk);
         month_first_day <= 1'b1;
         @(posedge mclk);
         month_first_day <= 1'b0;
         idle(4);
         check(irq_pin, (i != 2) ? 1'b1 : 1'b0, "month event pin");
         rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'h00000004, (i == 2) ? 32'h4 : 32'h0, "flag mirror");
      end
      wr(`RTCPI_IDX_CTRL_SECOND, 8'h04);
      idle(3);
      check(irq_pin, 1'b0, "pin held");
      wr(`RTCPI_IDX_CTRL_SECOND, 8'h00);
      idle(3);
      check(irq_pin, 1'b1, "pin released");
      rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'h00000004, 32'h00000000, "flag cleared");
      $display("test level done");
   endtask : t_level

   task automatic t_power;
      wr(`RTCPI_IDX_RATE_TRIM, 8'h3F);
      wr(`RTCPI_IDX_CTRL_FIRST, 8'h06);
      @(posedge mclk);
      power_on_detect <= 1'b1;
      idle(4);
      power_on_detect <= 1'b0;
      idle(4);
      rd_chk(`RTCPI_IDX_RATE_TRIM, 32'hFFFFFFFF, 32'h00000000, "trim default");
      rd_chk(`RTCPI_IDX_CTRL_FIRST, 32'hFFFFFFFF, 32'h00000000, "ctrl1 default");
      rd_chk(`RTCPI_IDX_CTRL_SECOND, 32'h00000014, 32'h00000010, "pon set");
      $display("test power done");
   endtask : t_power

   // ----------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      osc_32k = 1'b0;
      power_on_detect = 1'b0;
      month_first_day = 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_ref();
      t_pulse();
      t_level();
      t_power();
      wrap_up();
   end

   initial begin
      repeat (99000) @(posedge mclk);
      failures++;
      wrap_up();
   end
endmodule : rtcpi_trim_irq_tb
